/* File: logic/boot_enum_defines.svh */
// constants of the boot and enumeration control block
`ifndef BOOT_ENUM_DEFINES_SVH
`define BOOT_ENUM_DEFINES_SVH
`define BOOT_CODE_ID_SUBST 8'hc0
`define BOOT_CODE_RAM_LOAD 8'hc2
`define EEPROM_DEV_ADDR 7'h50
`define USB_IRQ_SOURCES 27
`define FIFO_IRQ_SOURCES 14
`define USB_IRQ_VECTOR 16'h0043
// top digit of the default release value, value arbitrary
`define RELEASE_HIGH_DIGIT 4'h3
`define I2C_QUARTER_CYCLES 10'd625
`define ID_LOAD_BYTES 16'd7
`endif

/* File: logic/boot_enum_pkg.sv */
// types of the boot and enumeration control block
package boot_enum_pkg;
  typedef enum logic [1:0] {
    BOOT_NONE,
    BOOT_ID_SUBST,
    BOOT_RAM_LOAD
  } boot_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_BYTE,
    ST_ACK,
    ST_RBYTE,
    ST_RACK,
    ST_STOP,
    ST_DONE
  } i2c_state_t;
endpackage

/* File: logic/i2c_byte_engine.sv */
// i2c byte engine: start, write byte, read byte, stop
`timescale 1ns/10ps
`include "boot_enum_defines.svh"
module i2c_byte_engine
  import boot_enum_pkg::*;
#(
  parameter int QUARTER_CYCLES = `I2C_QUARTER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  i2c_rd_if.engine req,
  input wire logic scl_sync,
  input wire logic sda_sync,
  output logic scl_oe,
  output logic sda_oe
);
  // op: 0 start+write, 1 write, 2 read, 3 stop
  typedef struct packed {
    i2c_state_t st;
    logic [9:0] tick;
    logic [1:0] phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic last;
    logic nack;
    logic done;
    logic scl_oe;
    logic sda_oe;
  } eng_t;
  eng_t r, next_r;
  logic tick_end;

  assign req.done = r.done;
  assign req.nack = r.nack;
  assign req.rdata = r.shift;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;
  assign tick_end = (r.tick == 10'(QUARTER_CYCLES - 1));

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.tick = tick_end ? 10'd0 : r.tick + 10'd1;
    case (r.st)
      ST_IDLE: begin
        next_r.tick = 10'd0;
        next_r.phase = 2'd0;
        if (req.start) begin
          next_r.shift = req.wdata;
          next_r.last = req.last;
          next_r.bit_cnt = 3'd7;
          case (req.op)
            2'd0: next_r.st = ST_START;
            2'd1: next_r.st = ST_BYTE;
            2'd2: begin
              next_r.st = ST_RBYTE;
              next_r.sda_oe = 1'b0;
            end
            default: next_r.st = ST_STOP;
          endcase
        end
      end
      ST_START: if (tick_end) begin
        next_r.phase = r.phase + 2'd1;
        case (r.phase)
          2'd0: begin
            next_r.sda_oe = 1'b0;
            next_r.scl_oe = 1'b0;
          end
          2'd1: next_r.sda_oe = 1'b1;
          2'd2: next_r.scl_oe = 1'b1;
          default: begin
            next_r.st = ST_BYTE;
            next_r.phase = 2'd0;
          end
        endcase
      end
      ST_BYTE, ST_ACK, ST_RBYTE, ST_RACK: if (tick_end) begin
        next_r.phase = r.phase + 2'd1;
        case (r.phase)
          2'd0: begin
            // data changes while the clock is low
            if (r.st == ST_BYTE) next_r.sda_oe = ~r.shift[7];
            else if (r.st == ST_RACK) next_r.sda_oe = ~r.last;
            else next_r.sda_oe = 1'b0;
          end
          2'd1: next_r.scl_oe = 1'b0;
          2'd2: begin
            // honour clock stretching by holding until the line is seen high
            if (!scl_sync) next_r.phase = r.phase;
            else if (r.st == ST_RBYTE) next_r.shift = {r.shift[6:0], sda_sync};
            else if (r.st == ST_ACK) next_r.nack = sda_sync;
          end
          default: begin
            next_r.scl_oe = 1'b1;
            next_r.phase = 2'd0;
            if (r.st == ST_BYTE) begin
              next_r.shift = {r.shift[6:0], 1'b0};
              if (r.bit_cnt == 3'd0) next_r.st = ST_ACK;
              next_r.bit_cnt = r.bit_cnt - 3'd1;
            end else if (r.st == ST_RBYTE) begin
              if (r.bit_cnt == 3'd0) next_r.st = ST_RACK;
              next_r.bit_cnt = r.bit_cnt - 3'd1;
            end else begin
              // sda is let go in a later low phase, never on the falling clock edge itself
              next_r.st = ST_DONE;
            end
          end
        endcase
      end
      ST_STOP: if (tick_end) begin
        next_r.phase = r.phase + 2'd1;
        case (r.phase)
          2'd0: next_r.sda_oe = 1'b1;
          2'd1: next_r.scl_oe = 1'b0;
          2'd2: next_r.sda_oe = 1'b0;
          default: next_r.st = ST_DONE;
        endcase
      end
      ST_DONE: begin
        next_r.done = 1'b1;
        next_r.st = ST_IDLE;
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end
endmodule

/* File: logic/i2c_rd_if.sv */
// request and answer signals between the loader and its i2c byte engine
`timescale 1ns/10ps
interface i2c_rd_if;
  logic start;
  logic [1:0] op;
  logic [7:0] wdata;
  logic last;
  logic done;
  logic nack;
  logic [7:0] rdata;
  modport master (output start, output op, output wdata, output last, input done, input nack, input rdata);
  modport engine (input start, input op, input wdata, input last, output done, output nack, output rdata);
endinterface

/* File: logic/usb_boot_enumeration_control.sv */
// power-up eeprom probe, boot mode choice, identity values and reconnect control
//
// Behaviour
// R01 - probe eeprom and read first byte first
// R02 - code c0 takes identities from eeprom
// R03 - code c2 boot-loads eeprom into ram
// R04 - no eeprom means built-in descriptors, defaults
// R05 - default release carries chip revision digits
// R06 - enumerate, accept download, then enumerate again
// R07 - disconnect request set makes device detached
// R08 - disconnect request cleared reconnects device
// R09 - ownership bit 0: built-in logic answers ep0
// R10 - ownership bit 1: firmware answers ep0
// R11 - firmware sets ownership before reconnecting
// R12 - 27 usb and 14 fifo autovector sources
// R13 - usb interrupt pushes pc, vectors to 0043; block only supplies vector 0043, no pc push
// R14 - unknown first byte treated as no eeprom
`timescale 1ns/10ps
`include "boot_enum_defines.svh"
module usb_boot_enumeration_control
  import boot_enum_pkg::*;
#(
  parameter int RAM_AW = 14,
  parameter logic [15:0] DEFAULT_VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEFAULT_PRODUCT_ID = 16'h5678, // arbitrary value
  parameter logic [11:0] CHIP_REVISION = 12'h001,
  parameter logic [15:0] LOAD_LENGTH = 16'h0100,
  parameter int QUARTER_CYCLES = `I2C_QUARTER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic disconnect_request,
  input wire logic firmware_owns_requests,
  input wire logic [4:0] usb_event_source,
  input wire logic usb_event_valid,
  input wire logic [3:0] fifo_engine_source,
  input wire logic fifo_engine_valid,
  output logic boot_done,
  output logic [1:0] boot_mode,
  output logic [15:0] vendor_id,
  output logic [15:0] product_id,
  output logic [15:0] release_id,
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic usb_attach,
  output logic ep0_to_firmware,
  output logic usb_event_interrupt,
  output logic [15:0] usb_vector_addr,
  output logic fifo_engine_interrupt,
  output logic [3:0] fifo_engine_vector
);
  typedef enum logic [2:0] {
    L_ADDR_W,
    L_OFFSET,
    L_ADDR_R,
    L_READ,
    L_STOP,
    L_RUN
  } load_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    load_t ls;
    logic busy;
    logic [15:0] count;
    logic [7:0] first;
    logic [55:0] idbuf;
    boot_mode_t mode;
    logic boot_done;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [15:0] rel;
    logic ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [7:0] ram_wdata;
    logic attach;
    logic owner;
    logic usb_irq;
    logic [15:0] usb_vec;
    logic fifo_irq;
    logic [3:0] fifo_vec;
  } top_t;
  top_t r, next_r;
  logic [15:0] total;

  i2c_rd_if bus();
  logic eng_scl_oe;
  logic eng_sda_oe;

  i2c_byte_engine #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_engine (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .req(bus),
    .scl_sync(r.scl_s[1]),
    .sda_sync(r.sda_s[1]),
    .scl_oe(eng_scl_oe),
    .sda_oe(eng_sda_oe)
  );

  // engine drive is already registered; open drain so the output level is low
  assign scl_oe = eng_scl_oe;
  assign sda_oe = eng_sda_oe;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign boot_done = r.boot_done;
  assign boot_mode = r.mode;
  assign vendor_id = r.vid;
  assign product_id = r.pid;
  assign release_id = r.rel;
  assign ram_we = r.ram_we;
  assign ram_addr = r.ram_addr;
  assign ram_wdata = r.ram_wdata;
  assign usb_attach = r.attach;
  assign ep0_to_firmware = r.owner;
  assign usb_event_interrupt = r.usb_irq;
  assign usb_vector_addr = r.usb_vec;
  assign fifo_engine_interrupt = r.fifo_irq;
  assign fifo_engine_vector = r.fifo_vec;

  assign total = (r.mode == BOOT_RAM_LOAD) ? LOAD_LENGTH : `ID_LOAD_BYTES;

  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[0], scl_in};
    next_r.sda_s = {r.sda_s[0], sda_in};
    next_r.ram_we = 1'b0;
    bus.start = 1'b0;
    bus.op = 2'd0;
    bus.wdata = 8'h00;
    bus.last = 1'b0;
    if (!r.busy && r.ls != L_RUN) begin
      next_r.busy = 1'b1;
      bus.start = 1'b1;
      case (r.ls)
        L_ADDR_W: bus.wdata = {`EEPROM_DEV_ADDR, 1'b0}; // [R01]
        L_OFFSET: begin
          bus.op = 2'd1;
          bus.wdata = 8'h00;
        end
        L_ADDR_R: bus.wdata = {`EEPROM_DEV_ADDR, 1'b1};
        L_READ: begin
          bus.op = 2'd2;
          // an unknown first byte is followed by one nacked read so the eeprom lets go before stop
          bus.last = (r.count == total) || (r.count != 16'd0 && r.mode == BOOT_NONE);
        end
        default: bus.op = 2'd3;
      endcase
    end
    if (bus.done) begin
      next_r.busy = 1'b0;
      case (r.ls)
        L_ADDR_W, L_OFFSET, L_ADDR_R: begin
          if (bus.nack) begin
            next_r.mode = BOOT_NONE; // [R04]
            next_r.ls = L_STOP;
          end else begin
            next_r.ls = load_t'(r.ls + 3'd1);
          end
        end
        L_READ: begin
          next_r.count = r.count + 16'd1;
          if (r.count == 16'd0) begin
            next_r.first = bus.rdata; // [R01]
            if (bus.rdata == `BOOT_CODE_ID_SUBST) next_r.mode = BOOT_ID_SUBST; // [R02]
            else if (bus.rdata == `BOOT_CODE_RAM_LOAD) next_r.mode = BOOT_RAM_LOAD; // [R03]
            else next_r.mode = BOOT_NONE; // [R14]
          end else begin
            if (r.mode == BOOT_RAM_LOAD) begin
              next_r.ram_we = 1'b1; // [R03]
              next_r.ram_addr = RAM_AW'(r.count - 16'd1);
              next_r.ram_wdata = bus.rdata;
            end else begin
              next_r.idbuf = {r.idbuf[47:0], bus.rdata};
            end
            if (r.count == total || r.mode == BOOT_NONE) next_r.ls = L_STOP; // [R14]
          end
        end
        L_STOP: begin
          next_r.ls = L_RUN;
          next_r.boot_done = 1'b1; // [R06]
          if (r.mode == BOOT_ID_SUBST) begin
            // bytes 1..6: vid, pid, release, each low byte first
            next_r.vid = {r.idbuf[47:40], r.idbuf[55:48]}; // [R02]
            next_r.pid = {r.idbuf[31:24], r.idbuf[39:32]};
            next_r.rel = {r.idbuf[15:8], r.idbuf[23:16]};
          end
        end
        default: next_r.ls = L_RUN;
      endcase
    end
    // stay detached until boot completes, then follow firmware's request
    next_r.attach = r.boot_done && !disconnect_request; // [R07] [R08] [R06]
    next_r.owner = firmware_owns_requests; // [R09] [R10]
    next_r.usb_irq = usb_event_valid && (usb_event_source < 5'(`USB_IRQ_SOURCES)); // [R12]
    if (usb_event_valid) begin
      next_r.usb_vec = `USB_IRQ_VECTOR; // [R13]
    end
    next_r.fifo_irq = fifo_engine_valid && (fifo_engine_source < 4'(`FIFO_IRQ_SOURCES)); // [R12]
    if (fifo_engine_valid) next_r.fifo_vec = fifo_engine_source;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
      r.ls <= L_ADDR_W;
      r.mode <= BOOT_NONE;
      r.vid <= DEFAULT_VENDOR_ID; // [R04]
      r.pid <= DEFAULT_PRODUCT_ID;
      r.rel <= {`RELEASE_HIGH_DIGIT, CHIP_REVISION}; // [R05]
      r.usb_vec <= `USB_IRQ_VECTOR;
    end else begin
      r <= next_r;
    end
  end
endmodule

/* File: verif/boot_enum_assertions.sv */
// port assertions of the boot and enumeration control block
`timescale 1ns/10ps
`include "boot_enum_defines.svh"
module boot_enum_assertions
  import boot_enum_pkg::*;
#(
  parameter logic [11:0] CHIP_REVISION = 12'h001
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic disconnect_request,
  input wire logic firmware_owns_requests,
  input wire logic [4:0] usb_event_source,
  input wire logic usb_event_valid,
  input wire logic [3:0] fifo_engine_source,
  input wire logic fifo_engine_valid,
  input wire logic boot_done,
  input wire logic [1:0] boot_mode,
  input wire logic [15:0] release_id,
  input wire logic ram_we,
  input wire logic usb_attach,
  input wire logic ep0_to_firmware,
  input wire logic usb_event_interrupt,
  input wire logic [15:0] usb_vector_addr,
  input wire logic fifo_engine_interrupt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_reconnect;
    boot_done && $fell(disconnect_request);
  endsequence
  property p_early;
    !boot_done |=> !usb_attach;
  endproperty
  property p_release;
    boot_done && boot_mode == BOOT_NONE |-> release_id == {`RELEASE_HIGH_DIGIT, CHIP_REVISION};
  endproperty
  property p_stands;
    boot_done |=> boot_done;
  endproperty
  property p_detach;
    boot_done && disconnect_request |=> !usb_attach;
  endproperty
  property p_attach;
    s_reconnect |=> usb_attach;
  endproperty
  property p_builtin;
    !firmware_owns_requests |=> !ep0_to_firmware;
  endproperty
  property p_owned;
    firmware_owns_requests |=> ep0_to_firmware;
  endproperty
  property p_usb_irq;
    $past(nrst) |-> usb_event_interrupt == ($past(usb_event_valid) && ($past(usb_event_source) < 5'd27));
  endproperty
  property p_fifo_irq;
    $past(nrst) |-> fifo_engine_interrupt == ($past(fifo_engine_valid) && ($past(fifo_engine_source) < 4'd14));
  endproperty
  property p_vector;
    usb_event_interrupt |-> usb_vector_addr == 16'h0043;
  endproperty
  property p_ram;
    ram_we |-> !boot_done;
  endproperty
  a_early: assert property (p_early) else $error("attach before probe end");
  a_release: assert property (p_release) else $error("default release wrong");
  a_stands: assert property (p_stands) else $error("boot done dropped");
  a_detach: assert property (p_detach) else $error("still attached");
  a_attach: assert property (p_attach) else $error("no reconnect");
  a_builtin: assert property (p_builtin) else $error("ep0 not built in");
  a_owned: assert property (p_owned) else $error("ep0 not to firmware");
  a_usb_irq: assert property (p_usb_irq) else $error("usb irq qualify wrong");
  a_fifo_irq: assert property (p_fifo_irq) else $error("fifo irq qualify wrong");
  a_vector: assert property (p_vector) else $error("usb vector wrong");
  a_ram: assert property (p_ram) else $error("ram write after boot");
endmodule
bind usb_boot_enumeration_control boot_enum_assertions #(.CHIP_REVISION(CHIP_REVISION)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .disconnect_request(disconnect_request),
  .firmware_owns_requests(firmware_owns_requests), .usb_event_source(usb_event_source),
  .usb_event_valid(usb_event_valid), .fifo_engine_source(fifo_engine_source),
  .fifo_engine_valid(fifo_engine_valid), .boot_done(boot_done), .boot_mode(boot_mode),
  .release_id(release_id), .ram_we(ram_we), .usb_attach(usb_attach), .ep0_to_firmware(ep0_to_firmware),
  .usb_event_interrupt(usb_event_interrupt), .usb_vector_addr(usb_vector_addr),
  .fifo_engine_interrupt(fifo_engine_interrupt));

/* File: verif/eeprom_model.sv */
// behavioural i2c serial eeprom, 8 bytes, on pulled-up lines
`timescale 1ns/10ps
`include "boot_enum_defines.svh"
module eeprom_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic present,
  input wire logic [63:0] image,
  output logic pull
);
  logic [7:0] sh, cur;
  logic [2:0] ptr;
  logic active, first, rd, rd_next, acked, mack;
  int bitn;
  initial begin
    pull = 1'b0;
    active = 1'b0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    {active, first, rd, pull, mack} = 5'b11000;
    // the clock fall that closes the start is not a data bit
    bitn = -1;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0;
    pull = 1'b0;
  end
  always @(posedge scl) if (active) begin
    if (bitn < 8 && !rd) sh = {sh[6:0], sda};
    if (bitn == 8 && rd) mack = !sda;
  end
  // the line changes only while the clock is low
  always @(negedge scl) if (active) begin
    bitn = bitn + 1;
    if (bitn == 8) begin
      if (!rd && first) begin
        acked = present && sh[7:1] == `EEPROM_DEV_ADDR;
        rd_next = sh[0];
      end else if (!rd) ptr = sh[2:0];
      pull = acked && !rd;
    end else if (bitn == 9) begin
      bitn = 0;
      first = 1'b0;
      pull = 1'b0;
      if (!acked || (rd && !mack)) active = 1'b0;
      else begin
        if (rd) ptr = ptr + 3'd1;
        rd = rd_next;
        cur = image[8*ptr +: 8];
        pull = rd && !cur[7];
      end
    end else if (rd) pull = !cur[7-bitn];
  end
endmodule

/* File: verif/test_usb_boot_enumeration_control.sv */
// self-checking bench of the boot and enumeration control block
`timescale 1ns/10ps
`include "boot_enum_defines.svh"
module test_usb_boot_enumeration_control;
  import boot_enum_pkg::*;
  localparam logic [11:0] REV = 12'h001;
  localparam logic [15:0] VID = 16'h1234; // arbitrary value
  localparam logic [15:0] PID = 16'h5678; // arbitrary value
  logic clk_sys = 1'b0, nrst = 1'b0, dis = 1'b0, own = 1'b0, uval = 1'b0, fval = 1'b0, present = 1'b0;
  logic [4:0] usrc = 5'h00;
  logic [3:0] fsrc = 4'h0;
  logic [63:0] image = 64'h0;
  logic pull, scl_oe, sda_oe, done, we, attach, ep0fw, uirq, firq;
  logic [1:0] mode;
  logic [15:0] vid, pid, rel, vaddr;
  logic [13:0] raddr;
  logic [7:0] rdat;
  logic [3:0] fvec;
  int num_errors = 0, n_compared = 0, nwr = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || pull);
  always #2 clk_sys = ~clk_sys;
  usb_boot_enumeration_control #(.CHIP_REVISION(REV), .DEFAULT_VENDOR_ID(VID), .DEFAULT_PRODUCT_ID(PID),
    .LOAD_LENGTH(16'h0004), .QUARTER_CYCLES(8)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .disconnect_request(dis), .firmware_owns_requests(own),
    .usb_event_source(usrc), .usb_event_valid(uval), .fifo_engine_source(fsrc), .fifo_engine_valid(fval),
    .boot_done(done), .boot_mode(mode), .vendor_id(vid), .product_id(pid), .release_id(rel), .ram_we(we),
    .ram_addr(raddr), .ram_wdata(rdat), .usb_attach(attach), .ep0_to_firmware(ep0fw),
    .usb_event_interrupt(uirq), .usb_vector_addr(vaddr), .fifo_engine_interrupt(firq),
    .fifo_engine_vector(fvec));
  eeprom_model u_rom (.scl(scl), .sda(sda), .present(present), .image(image), .pull(pull));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk_sys) if (we === 1'b1) begin
    check({2'b0, raddr}, 16'(nwr));
    check({8'h0, rdat}, {8'h0, image[8*nwr+8 +: 8]});
    nwr++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic boot(input logic p, input logic [63:0] img);
    int i;
    @(posedge clk_sys);
    {present, image, nrst} <= {p, img, 1'b0};
    nwr = 0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    for (i = 0; i < 20000 && done !== 1'b1; i++) @(posedge clk_sys);
    if (done !== 1'b1) begin
      num_errors++;
      report_and_stop;
    end else begin
      tick(1);
    end
  endtask
  task automatic ids(input logic [1:0] m, input logic [15:0] v, input logic [15:0] p, input logic [15:0] r);
    check({14'h0, mode}, {14'h0, m});
    check(vid, v);
    check(pid, p);
    check(rel, r);
  endtask
  task automatic t_none;
    boot(1'b0, 64'h0);
    ids(BOOT_NONE, VID, PID, {`RELEASE_HIGH_DIGIT, REV});
    check({15'h0, attach}, 16'h1);
    @(posedge clk_sys) dis <= 1'b1;
    tick(1);
    check({15'h0, attach}, 16'h0);
    @(posedge clk_sys) own <= 1'b1;
    @(posedge clk_sys) dis <= 1'b0;
    tick(1);
    check({15'h0, attach}, 16'h1);
    check({15'h0, ep0fw}, 16'h1);
    @(posedge clk_sys) own <= 1'b0;
    tick(1);
    check({15'h0, ep0fw}, 16'h0);
  endtask
  task automatic t_irq;
    int s;
    for (s = 25; s < 29; s++) begin
      @(posedge clk_sys) {uval, usrc, fval, fsrc} <= {1'b1, 5'(s), 1'b1, 4'(s - 14)};
      tick(1);
      check({15'h0, uirq}, {15'h0, s < 27});
      check({15'h0, firq}, {15'h0, s < 28});
      check({12'h0, fvec}, 16'(s - 14));
      if (s < 27) check(vaddr, 16'h0043);
    end
    @(posedge clk_sys) {uval, fval} <= 2'b00;
    tick(1);
    check({14'h0, uirq, firq}, 16'h0);
  endtask
  initial begin
    t_none;
    t_irq;
    boot(1'b1, 64'h0001_02ca_febe_efc0);
    ids(BOOT_ID_SUBST, 16'hbeef, 16'hcafe, 16'h0102);
    boot(1'b1, 64'h0000_0044_3322_11c2);
    check({14'h0, mode}, {14'h0, BOOT_RAM_LOAD});
    check(16'(nwr), 16'h0004);
    boot(1'b1, 64'h0001_02ca_febe_efc1);
    ids(BOOT_NONE, VID, PID, {`RELEASE_HIGH_DIGIT, REV});
    report_and_stop;
  end
endmodule
